// File: rtl/aic_top.sv
// audio input pins: oversample clock, bit clock, word select, registers
`timescale 1ns/1ps
module aic_top (
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             OVERSAMPLE_CLOCK_OUT_O,
  input  wire logic        SERIAL_BIT_CLOCK_I,
  output logic             SERIAL_BIT_CLOCK_O,
  output logic             SERIAL_BIT_CLOCK_OE_O,
  input  wire logic        WORD_SELECT_I,
  output logic             WORD_SELECT_O,
  output logic             WORD_SELECT_OE_O,
  input  wire logic        SERIAL_DATA_IN_I,
  output logic             SAMPLE_STB_O,
  output logic      [15:0] LEFT_O,
  output logic      [15:0] RIGHT_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  aic_pkg::aic_top_st_t r_reg;
  aic_pkg::aic_top_st_t r_next;
  aic_pkg::aic_smp_t    smp;
  logic                 osc;
  logic                 osc_edge;
  logic                 master;
  logic                 bclk;
  logic                 rise;
  logic                 fall;
  logic                 samp;
  logic                 launch;
  logic                 rx_ws;
  logic                 rx_stb;

  // ****************************************************************
  // synthesizer and receiver
  // ****************************************************************

  // the synthesizer reads the live frequency word, so a write takes
  // effect on the next step without stopping the clock
  aic_dds i_aic_dds (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .freq_i   (r_reg.freq),
    .osc_o    (osc)
  );

  aic_rx i_aic_rx (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .samp_i   (samp),
    .ws_i     (rx_ws),
    .sd_i     (r_reg.sd_s2),
    .cfg_i    (r_reg.cfg),
    .lay_i    (r_reg.lay),
    .stb_o    (rx_stb),
    .smp_o    (smp)
  );

  // ****************************************************************
  // edge detection
  // ****************************************************************

  // bit clock seen by the receiver: own divider output as master,
  // second synchroniser stage as slave
  always_comb begin
    master   = r_reg.cfg.timing_master_select;
    osc_edge = osc != r_reg.osc_prev;
    bclk     = master ? r_reg.sck_out : r_reg.sck_s2;
    rise     = bclk && !r_reg.bclk_prev;
    fall     = !bclk && r_reg.bclk_prev;
    samp     = r_reg.cfg.sample_edge ? fall : rise;
    launch   = r_reg.cfg.sample_edge ? rise : fall;
    rx_ws    = master ? r_reg.ws_out : r_reg.ws_s2;
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  // slave pins cross through two flops each; a slave bit clock is only
  // followed up to a quarter of the main clock rate
  always_comb begin
    r_next           = r_reg;
    r_next.rdata     = 32'h0000_0000;
    r_next.sck_s1    = SERIAL_BIT_CLOCK_I;
    r_next.sck_s2    = r_reg.sck_s1;
    r_next.ws_s1     = WORD_SELECT_I;
    r_next.ws_s2     = r_reg.ws_s1;
    r_next.sd_s1     = SERIAL_DATA_IN_I;
    r_next.sd_s2     = r_reg.sd_s1;
    r_next.osc_prev  = osc;
    r_next.bclk_prev = bclk;

    // bit clock divider counts oversample half periods, so one bit
    // clock period spans divider plus one oversample periods; at most
    // half the main clock, well under the bit clock ceiling
    if (master) begin
      if (osc_edge) begin
        if (r_reg.div_cnt == r_reg.cfg.bit_clock_divider) begin
          r_next.div_cnt = 8'h00;
          r_next.sck_out = !r_reg.sck_out;
        end else begin
          r_next.div_cnt = r_reg.div_cnt + 8'h01;
        end
      end
      // word select low for the first half of the frame, high after
      if (launch) begin
        if (r_reg.bit_cnt >= r_reg.cfg.frame_length_divider) begin
          r_next.bit_cnt = 9'h000;
        end else begin
          r_next.bit_cnt = r_reg.bit_cnt + 9'h001;
        end
        r_next.ws_out = r_next.bit_cnt >
                        (r_reg.cfg.frame_length_divider >> 1);
      end
    end

    // register writes, accepted at any time
    if (WR_I) begin
      if (ADDR_I == aic_pkg::OFF_SERIAL_CFG) begin
        r_next.cfg = aic_pkg::aic_cfg_t'(WDATA_I);
      end else if (ADDR_I == aic_pkg::OFF_SYNTH) begin
        r_next.freq = WDATA_I;
      end else if (ADDR_I == aic_pkg::OFF_LAYOUT) begin
        r_next.lay = aic_pkg::aic_layout_t'(WDATA_I);
      end
    end

    // slave, or a write that leaves master mode, clears the master
    // timing on that same edge, so a released pin never shows stale level
    if (!r_next.cfg.timing_master_select) begin
      r_next.div_cnt = 8'h00;
      r_next.sck_out = 1'b0;
      r_next.bit_cnt = 9'h000;
      r_next.ws_out  = 1'b0;
    end

    // read data stands only in the cycle after the strobe
    if (RD_I) begin
      if (ADDR_I == aic_pkg::OFF_SERIAL_CFG) begin
        r_next.rdata = r_reg.cfg;
      end else if (ADDR_I == aic_pkg::OFF_SYNTH) begin
        r_next.rdata = r_reg.freq;
      end else if (ADDR_I == aic_pkg::OFF_LAYOUT) begin
        r_next.rdata = r_reg.lay;
      end else if (ADDR_I == aic_pkg::OFF_SAMPLE) begin
        r_next.rdata = smp;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // everything clears to timing slave with pins released
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      r_reg      <= '0;
      r_reg.cfg  <= aic_pkg::CFG_RST;
      r_reg.freq <= aic_pkg::SYNTH_RST;
      r_reg.lay  <= aic_pkg::LAYOUT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // oversample pin is the synthesizer flop itself, in every mode
  assign OVERSAMPLE_CLOCK_OUT_O = osc;
  assign RDATA_O                = r_reg.rdata;
  assign SERIAL_BIT_CLOCK_O     = r_reg.sck_out;
  assign SERIAL_BIT_CLOCK_OE_O  = r_reg.cfg.timing_master_select;
  assign WORD_SELECT_O          = r_reg.ws_out;
  assign WORD_SELECT_OE_O       = r_reg.cfg.timing_master_select;
  assign SAMPLE_STB_O           = rx_stb;
  assign LEFT_O                 = smp.left;
  assign RIGHT_O                = smp.right;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking dcb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  slave_pins_a : assert property (WR_I &&
    ADDR_I == 8'h00 && !WDATA_I[0] |=>
    !SERIAL_BIT_CLOCK_OE_O && !WORD_SELECT_OE_O && !SERIAL_BIT_CLOCK_O)
    else $error("slave mode still drives pins");
  master_pins_a : assert property (WR_I &&
    ADDR_I == 8'h00 && WDATA_I[0] |=>
    SERIAL_BIT_CLOCK_OE_O && WORD_SELECT_OE_O)
    else $error("master mode pins not driven");
  sck_div_a : assert property ($past(master) && master &&
    $changed(r_reg.sck_out) |->
    $past(osc_edge) && $past(r_reg.div_cnt) ==
    $past(r_reg.cfg.bit_clock_divider))
    else $error("bit clock toggled off divider count");
  ws_launch_a : assert property ($past(master) && master &&
    $changed(r_reg.ws_out) |-> $past(launch))
    else $error("word select moved on sampling edge");
  slave_sync_a : assert property (!master && $past(ARST_N_I, 2) |->
    r_reg.sck_s2 == $past(SERIAL_BIT_CLOCK_I, 2))
    else $error("bit clock synchroniser depth wrong");
  edge_sel_a : assert property (!master && $past(!master) && samp |->
    r_reg.sck_s2 == !r_reg.cfg.sample_edge &&
    $past(r_reg.sck_s2) == r_reg.cfg.sample_edge)
    else $error("data sampled on wrong bit clock edge");
  frame_len_a : assert property (master |->
    r_reg.bit_cnt <= r_reg.cfg.frame_length_divider ||
    $changed(r_reg.cfg))
    else $error("frame counter past frame length");
  read_once_a : assert property (RD_I ##1 !RD_I |=>
    RDATA_O == 32'h0000_0000)
    else $error("read data held past its cycle");

  master_frame_c : cover property (master && SAMPLE_STB_O);
  slave_frame_c  : cover property (!master && SAMPLE_STB_O);
  freq_write_c   : cover property (WR_I && ADDR_I == 8'h04 &&
                                   WDATA_I[31]);

endmodule : aic_top

// File: include/aic_pkg.sv
// constants, register layouts and state records for the audio input clocks
// Contract
// - synthesizer output always drives the oversample clock pin
// - synthesizer programmable up to 40 MHz, resolution below 0.3 Hz; the code gives at most half the main clock, 5 MHz
// - after reset the unit is timing slave, bit clock is an input
// - slave bit clock is asynchronous, crossed into the main clock safely
// - master mode drives bit clock, integer division of oversample clock
// - bit clock never above 22 MHz in either mode
// - serial data sampled on rising or falling edge per sample-edge bit
// - slave word select sampled on the data sampling edge
// - master word select changes on the edge opposite the sampling edge
// - receiver handles frames up to 512 bits with a valid qualifier bit
// - LSB-first 1 to 16 bits per channel and standard stereo I2S
// - frequency register may be written at any time while running
// - frequency bit 31 set selects improved low-jitter mode
// - frequency bit 31 clear selects legacy compatibility mode
// - improved: f = (value - 2^31) * 9 * fclk / 2^32
// - improved jitter at most one period of nine times clock; the code gives one main clock period of jitter
// - compatibility: f = value * 3 * fclk / 2^32
// - master select zero (reset) means inputs, one means outputs
// - master bit clock is oversample clock over divider plus one
// - master word select from frame divider, frame 1 to 512 bits
package aic_pkg;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam logic [7:0]  OFF_SERIAL_CFG = 8'h00;
  localparam logic [7:0]  OFF_SYNTH      = 8'h04;
  localparam logic [7:0]  OFF_LAYOUT     = 8'h08;
  localparam logic [7:0]  OFF_SAMPLE     = 8'h0c;
  localparam logic [31:0] CFG_RST        = 32'h0000_0000;
  localparam logic [31:0] SYNTH_RST      = 32'h0000_0000;
  localparam logic [31:0] LAYOUT_RST     = 32'h0000_0000;
  localparam int          SYNTH_MODE_BIT = 31;
  localparam logic [31:0] IMPROVED_MUL   = 32'h0000_0009;
  localparam logic [31:0] COMPAT_MUL     = 32'h0000_0003;
  localparam logic [8:0]  POS_MAX        = 9'h1ff;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int SCK_MAX_HZ  = 22_000_000;
  localparam int SCK_MIN_HALF_CYC =
    (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ) < 1 ? 1 :
    (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);

  // ****************************************************************
  // register layouts
  // ****************************************************************
  typedef struct packed {
    logic [6:0] rsv_hi;
    logic [8:0] frame_length_divider;
    logic [7:0] bit_clock_divider;
    logic       rsv_lo;
    logic [3:0] word_len_m1;
    logic       lsb_first;
    logic       sample_edge;
    logic       timing_master_select;
  } aic_cfg_t;

  typedef struct packed {
    logic [1:0] frame_mode;
    logic [8:0] valid_pos;
    logic [2:0] rsv;
    logic [8:0] right_pos;
    logic [8:0] left_pos;
  } aic_layout_t;

  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } aic_smp_t;

  // ****************************************************************
  // state records
  // ****************************************************************
  typedef struct packed {
    logic [31:0] phase;
    logic        osc;
  } aic_dds_st_t;

  typedef struct packed {
    logic [8:0] pos;
    logic       over;
    logic       ws_prev;
    logic       vbit;
    logic       started;
    logic       stb;
    aic_smp_t   cur;
    aic_smp_t   out;
  } aic_rx_st_t;

  typedef struct packed {
    aic_cfg_t    cfg;
    logic [31:0] freq;
    aic_layout_t lay;
    logic [31:0] rdata;
    logic        sck_s1;
    logic        sck_s2;
    logic        ws_s1;
    logic        ws_s2;
    logic        sd_s1;
    logic        sd_s2;
    logic        osc_prev;
    logic        bclk_prev;
    logic        sck_out;
    logic        ws_out;
    logic [7:0]  div_cnt;
    logic [8:0]  bit_cnt;
  } aic_top_st_t;

endpackage : aic_pkg

// File: rtl/aic_dds.sv
// square-wave phase accumulator synthesizer
`timescale 1ns/1ps
module aic_dds (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [31:0] freq_i,
  output logic             osc_o
);

  aic_pkg::aic_dds_st_t r_reg;
  aic_pkg::aic_dds_st_t r_next;
  logic [31:0]          step;

  // step per clock; the 9x rate of improved mode is folded into the step,
  // so jitter is one main clock period rather than a ninth of one
  always_comb begin
    if (freq_i[aic_pkg::SYNTH_MODE_BIT]) begin
      step = 32'({1'b0, freq_i[30:0]} * aic_pkg::IMPROVED_MUL);
    end else begin
      step = 32'(freq_i * aic_pkg::COMPAT_MUL);
    end
    r_next       = r_reg;
    r_next.phase = r_reg.phase + step;
    r_next.osc   = r_reg.phase[31];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign osc_o = r_reg.osc;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  improved_step_a : assert property (freq_i[31] |=>
    r_reg.phase - $past(r_reg.phase) ==
    32'({1'b0, $past(freq_i[30:0])} * 32'h9))
    else $error("improved mode step wrong");
  compat_step_a : assert property (!freq_i[31] |=>
    r_reg.phase - $past(r_reg.phase) == 32'($past(freq_i) * 32'h3))
    else $error("compatibility mode step wrong");
  osc_follow_a : assert property ($rose(r_reg.phase[31]) |=>
    $rose(r_reg.osc))
    else $error("oscillator lost accumulator msb");
  improved_run_c : cover property (freq_i[31] ##1 $rose(r_reg.osc));

endmodule : aic_dds

// File: rtl/aic_rx.sv
// serial frame position tracker and left/right sample capture
`timescale 1ns/1ps
module aic_rx (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         samp_i,
  input  wire logic         ws_i,
  input  wire logic         sd_i,
  input  aic_pkg::aic_cfg_t    cfg_i,
  input  aic_pkg::aic_layout_t lay_i,
  output logic              stb_o,
  output aic_pkg::aic_smp_t smp_o
);

  aic_pkg::aic_rx_st_t r_reg;
  aic_pkg::aic_rx_st_t r_next;
  logic [8:0]          li;
  logic [8:0]          ri;
  logic                accept;
  logic                fstart;

  // msb-first shifts in at the bottom, lsb-first writes by index
  function automatic logic [15:0] put(input logic [15:0] w,
                                      input logic [3:0]  idx,
                                      input logic        b,
                                      input logic        lsb);
    logic [15:0] v;
    v = w;
    if (lsb) begin
      v[idx] = b;
    end else begin
      v = {w[14:0], b};
    end
    return v;
  endfunction : put

  // frame starts at the falling word select seen on the sampling edge
  always_comb begin
    li     = r_reg.pos - lay_i.left_pos;
    ri     = r_reg.pos - lay_i.right_pos;
    fstart = r_reg.ws_prev && !ws_i;
    accept = !lay_i.frame_mode[1] || (r_reg.vbit == lay_i.frame_mode[0]);
    r_next     = r_reg;
    r_next.stb = 1'b0;
    if (samp_i) begin
      r_next.ws_prev = ws_i;
      if (fstart) begin
        r_next.pos     = 9'h000;
        r_next.over    = 1'b0;
        r_next.started = 1'b1;
        r_next.cur     = '0;
        if (r_reg.started && accept) begin
          r_next.out = r_reg.cur;
          r_next.stb = 1'b1;
        end
      end else if (!r_reg.over) begin
        if (r_reg.pos == lay_i.valid_pos) begin
          r_next.vbit = sd_i;
        end
        if (li <= {5'h00, cfg_i.word_len_m1}) begin
          r_next.cur.left = put(r_reg.cur.left, li[3:0], sd_i,
                                cfg_i.lsb_first);
        end
        if (ri <= {5'h00, cfg_i.word_len_m1}) begin
          r_next.cur.right = put(r_reg.cur.right, ri[3:0], sd_i,
                                 cfg_i.lsb_first);
        end
        if (r_reg.pos == aic_pkg::POS_MAX) begin
          r_next.over = 1'b1;
        end else begin
          r_next.pos = r_reg.pos + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign stb_o = r_reg.stb;
  assign smp_o = r_reg.out;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  frame_start_a : assert property (samp_i && fstart |=>
    r_reg.pos == 9'h000 && !r_reg.over)
    else $error("frame start did not clear position");
  pos_hold_a : assert property (samp_i && r_reg.over |=>
    r_reg.over && r_reg.pos == 9'h1ff)
    else $error("position moved past frame end");
  ws_edge_a : assert property (samp_i |=>
    r_reg.ws_prev == $past(ws_i))
    else $error("word select not taken on sampling edge");
  msb_shift_a : assert property (samp_i && !fstart && !r_reg.over &&
    !cfg_i.lsb_first && li <= {5'h00, cfg_i.word_len_m1} |=>
    r_reg.cur.left[0] == $past(sd_i))
    else $error("msb-first bit not shifted in");
  frame_out_c : cover property (r_reg.stb ##[1:600] r_reg.stb);

endmodule : aic_rx

// File: bench/aic_conv_model.sv
// behavioural stereo converter: bit clock, word select and data
`timescale 1ns/1ps
module aic_conv_model #(
  parameter int HALF_NS = 250
) (
  input  wire logic        en_i,
  input  wire logic        edge_i,
  input  wire logic        lsb_i,
  input  wire logic [15:0] left_i,
  input  wire logic [15:0] right_i,
  output logic             sck_o,
  output logic             ws_o,
  output logic             sd_o
);
  // ********
  // frame generator
  // ********
  logic ph;
  int   p;

  // ph rises on the sampling edge, so edge_i only flips the level
  assign sck_o = ph ^ edge_i;

  initial begin
    ph   = 1'b1;
    ws_o = 1'b1;
    sd_o = 1'b0;
  end

  // 40 slots a frame; frames run back to back while en_i is high, the clock stands still only with en_i low
  always begin
    wait (en_i);
    for (int j = 0; j < 40; j++) begin
      p    = j - 1;
      ph   = 1'b0;
      ws_o = (j >= 20);
      if (p >= 0 && p < 16) begin
        sd_o = left_i[lsb_i ? p : 15 - p];
      end else if (p >= 20 && p < 36) begin
        sd_o = right_i[lsb_i ? p - 20 : 35 - p];
      end else begin
        sd_o = j[0];  // idle slots toggle, position 38 carries a one
      end
      #(HALF_NS);
      ph = 1'b1;  // 250 ns halves keep the clock at 2 MHz
      #(HALF_NS);
    end
    sd_o = ~sd_o;  // released line must not hold the last bit
  end
endmodule : aic_conv_model

// File: bench/audio_input_serial_clock_port_bench.sv
// self-checking bench for the audio input clock and serial pins
`timescale 1ns/1ps
module audio_input_serial_clock_port_bench;
  // ********
  // clock, reset and wiring
  // ********
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        osc, sck_o, sck_oe, ws_o, ws_oe, stb;
  logic [15:0] left, right;
  logic [15:0] m_left = 16'h0;
  logic [15:0] m_right = 16'h0;
  logic        m_en = 1'b0;
  logic        m_edge = 1'b0;
  logic        m_lsb = 1'b0;
  logic        m_sck, m_ws, m_sd, sck_pin, ws_pin;
  int          err_count = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  // each pin carries whichever side has its enable up
  assign sck_pin = sck_oe ? sck_o : m_sck;
  assign ws_pin  = ws_oe ? ws_o : m_ws;

  aic_top i_aic_top (
    .CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OVERSAMPLE_CLOCK_OUT_O(osc),
    .SERIAL_BIT_CLOCK_I(sck_pin), .SERIAL_BIT_CLOCK_O(sck_o),
    .SERIAL_BIT_CLOCK_OE_O(sck_oe), .WORD_SELECT_I(ws_pin),
    .WORD_SELECT_O(ws_o), .WORD_SELECT_OE_O(ws_oe),
    .SERIAL_DATA_IN_I(m_sd), .SAMPLE_STB_O(stb), .LEFT_O(left),
    .RIGHT_O(right)
  );

  aic_conv_model i_aic_conv_model (
    .en_i(m_en), .edge_i(m_edge), .lsb_i(m_lsb), .left_i(m_left),
    .right_i(m_right), .sck_o(m_sck), .ws_o(m_ws), .sd_o(m_sd)
  );

  // ********
  // shared tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // sample one step after the edge so registered outputs have landed
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // ********
  // scenarios
  // ********
  task automatic t_bus;
    logic [31:0] d;
    check("sck oe", sck_oe, 0);
    check("ws oe", ws_oe, 0);
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'(4 * i), d);
      check("reset value", d, 0);
    end
    repeat (40) begin
      tick();
      check("osc idle", osc, 0);
    end
    wr_reg(8'h04, 32'h8123_4567);
    rd_reg(8'h04, d);
    check("synth readback", d, 32'h8123_4567);
    tick();
    check("rdata released", rdata, 0);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_reg(8'h10, d);
    check("unmapped read", d, 0);
    $display("test bus done");
  endtask : t_bus

  // lower 28 step bits are zero, so the msb pattern repeats every 16
  task automatic t_osc(input logic [31:0] f, input int exp);
    int   n;
    logic p;
    wr_reg(8'h04, f);
    repeat (20) tick();
    n = 0;
    p = osc;
    repeat (160) begin
      tick();
      if (osc === 1'b1 && p === 1'b0) n++;
      p = osc;
    end
    check("osc rises", n, exp);
    $display("test synth %h done", f);
  endtask : t_osc

  task automatic t_master(input logic e);
    aic_pkg::aic_cfg_t c;
    int   nr;
    int   nf;
    logic ps;
    logic pw;
    c = '0;
    c.timing_master_select = 1'b1;
    c.sample_edge          = e;
    c.bit_clock_divider    = 8'h06;
    c.frame_length_divider = 9'h004;
    wr_reg(8'h04, 32'h9000_0000);  // improved mode as source
    wr_reg(8'h00, c);
    tick();
    check("sck oe", sck_oe, 1);
    check("ws oe", ws_oe, 1);
    repeat (100) tick();
    nr = 0;
    nf = 0;
    ps = sck_o;
    pw = ws_o;
    // 7 osc periods per 16 cycles, divider 6 divides by 7: one bit clock per 16
    repeat (320) begin
      tick();
      if (sck_o === 1'b1 && ps === 1'b0) nr++;
      if (ws_o === 1'b0 && pw === 1'b1) nf++;
      if (ws_o !== pw) check("sck at ws change", sck_o, e);
      ps = sck_o;
      pw = ws_o;
    end
    check("bit clock rises", nr, 20);
    check("frame starts", nf, 4);
    $display("test master edge %0d done", e);
  endtask : t_master

  task automatic t_slave(input logic e, input logic lsb,
                         input logic [1:0] mode, input logic [15:0] l,
                         input logic [15:0] r, input logic acc);
    aic_pkg::aic_cfg_t    c;
    aic_pkg::aic_layout_t y;
    logic [31:0]          d;
    int                   seen;
    c             = '0;
    c.sample_edge = e;
    c.lsb_first   = lsb;
    c.word_len_m1 = 4'hf;
    y             = '0;
    y.frame_mode  = mode;
    y.valid_pos   = 9'h026;
    y.right_pos   = 9'h014;
    wr_reg(8'h00, c);
    wr_reg(8'h08, y);
    tick();
    check("slave sck oe", sck_oe, 0);
    m_edge  <= e;
    m_lsb   <= lsb;
    m_left  <= l;
    m_right <= r;
    m_en    <= 1'b1;
    seen = 0;
    for (int i = 0; i < 1200 && seen < 2; i++) begin
      tick();
      if (stb === 1'b1) seen++;
    end
    check("samples taken", seen, acc ? 2 : 0);
    if (acc) begin
      check("left word", left, l);
      check("right word", right, r);
      rd_reg(8'h0c, d);
      check("sample register", d, {r, l});
    end
    m_en <= 1'b0;
    repeat (300) tick();
    $display("test slave mode %0d done", mode);
  endtask : t_slave

  // ********
  // main sequence and watchdog
  // ********
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_bus();
    t_osc(32'h9000_0000, 70);
    t_osc(32'h1000_0000, 30);
    t_master(1'b0);
    t_master(1'b1);
    t_slave(1'b0, 1'b0, 2'b00, 16'h1234, 16'hc0de, 1'b1);
    t_slave(1'b1, 1'b1, 2'b11, 16'h8ace, 16'h0f31, 1'b1);
    t_slave(1'b0, 1'b0, 2'b10, 16'h5555, 16'haaaa, 1'b0);
    end_of_test();
  end

  // the tests need at most about 5800 cycles; a hang stops well after that
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule : audio_input_serial_clock_port_bench
